//--- hw/gcm_clock_network.sv
// quadrant clock network: 24 glitchless multiplexers, switch matrices, quadrant line selection
// assumes all clock sources are levels sampled on the system clock
//
// Function
// - select 0 forwards first clock input, select 1 forwards second.
// - switching never shortens a high or low phase below the inputs' shortest.
// - clocks may be asynchronous; select may change anytime except near selected rising edge.
// - plain buffer is the multiplexer element with selection fixed.
// - gated buffer builds its enable from the multiplexer select mechanism.
// - twenty-four multiplexer elements sit around the four edges.
// - four top and four bottom multiplexers reach all four quadrants.
// - left-edge multiplexers reach left quadrants only; right-edge ones right only.
// - paired multiplexers share inputs: one's first input is partner's second.
// - side pair matrix picks half-edge pin, interconnect line or clock manager.
// - top/bottom matrix picks two pins, one manager output, one interconnect.
// - first input is the primary path; second is the switching source.
// - top/bottom pair reaches four of eight edge pins, so differential pairs fit.
// - side pairs are fed by only two dedicated clock pins.
// - each quadrant has eight clock lines A to H for its logic.
// - each quadrant line takes global or same-letter half source, never both.
// - top and bottom outputs form two four-line spines joining an eight-line centre spine.
`timescale 1ns/100ps
module gcm_clock_network #(
  parameter bit HAS_SIDE_MANAGER = 1'b1
) (
  // system
  input logic clock,
  input logic rst_n,
  // dedicated clock pins
  input logic [gcm_pkg::GCM_GLOBAL_PINS-1:0] global_clock_pin,
  input logic [gcm_pkg::GCM_HALF_PINS-1:0] left_half_clock_pin,
  input logic [gcm_pkg::GCM_HALF_PINS-1:0] right_half_clock_pin,
  // clock manager outputs, one per matrix slot
  input logic [gcm_pkg::GCM_EDGE_SLOTS-1:0] global_manager_clock,
  input logic [gcm_pkg::GCM_EDGE_SLOTS-1:0] left_manager_clock,
  input logic [gcm_pkg::GCM_EDGE_SLOTS-1:0] right_manager_clock,
  // interconnect lines, one per pair
  input logic [gcm_pkg::GCM_LINES-1:0] global_fabric_clock,
  input logic [gcm_pkg::GCM_PAIRS-1:0] left_fabric_clock,
  input logic [gcm_pkg::GCM_PAIRS-1:0] right_fabric_clock,
  // switch matrix source per slot
  input gcm_pkg::gcm_src_e [gcm_pkg::GCM_EDGE_SLOTS-1:0] global_slot_src,
  input gcm_pkg::gcm_src_e [gcm_pkg::GCM_EDGE_SLOTS-1:0] left_slot_src,
  input gcm_pkg::gcm_src_e [gcm_pkg::GCM_EDGE_SLOTS-1:0] right_slot_src,
  // multiplexer selects, indexed by line
  input logic [gcm_pkg::GCM_LINES-1:0] global_select,
  input logic [gcm_pkg::GCM_LINES-1:0] left_select,
  input logic [gcm_pkg::GCM_LINES-1:0] right_select,
  // quadrant line source, one bit per line
  input logic [gcm_pkg::GCM_QUADS-1:0][gcm_pkg::GCM_LINES-1:0] quad_line_src,
  // plain buffer
  input logic plain_buffer_in,
  output logic plain_buffer_out,
  // gated buffer
  input logic gated_buffer_in,
  input logic gated_buffer_enable,
  output logic gated_buffer_out,
  // quadrant clock lines
  output logic [gcm_pkg::GCM_QUADS-1:0][gcm_pkg::GCM_LINES-1:0] quad_clock,
  // multiplexer status
  output logic [gcm_pkg::GCM_MUX_TOTAL-1:0] mux_running,
  output logic [gcm_pkg::GCM_MUX_TOTAL-1:0] mux_on_second
);
  import gcm_pkg::*;

  // one source per matrix slot
  function automatic logic slot_pick(
    input gcm_src_e code,
    input logic pin_a,
    input logic pin_b,
    input logic manager,
    input logic fabric,
    input logic allow_pin_b,
    input logic allow_manager
  );
    logic pick;
    pick = 1'b0;
    unique case (code)
      GCM_SRC_PIN_A: pick = pin_a;
      GCM_SRC_PIN_B: pick = allow_pin_b & pin_b;
      GCM_SRC_MANAGER: pick = allow_manager & manager;
      GCM_SRC_FABRIC: pick = fabric;
    endcase
    return pick;
  endfunction

  // alias pin reached by a global pair slot
  function automatic int alt_global_pin(input int pin);
    return (pin < GCM_BOTTOM_LINES) ? pin + GCM_ALT_SHIFT_BOTTOM : pin + GCM_ALT_SHIFT_TOP;
  endfunction

  // slot outputs of every matrix
  logic [GCM_EDGE_SLOTS-1:0] global_slot;
  logic [GCM_EDGE_SLOTS-1:0] left_slot;
  logic [GCM_EDGE_SLOTS-1:0] right_slot;

  // multiplexer inputs and outputs, indexed by line
  logic [GCM_LINES-1:0] global_first, global_second, global_out;
  logic [GCM_LINES-1:0] left_first, left_second, left_out;
  logic [GCM_LINES-1:0] right_first, right_second, right_out;
  logic [GCM_LINES-1:0] global_drive_first, global_drive_second;
  logic [GCM_LINES-1:0] left_drive_first, left_drive_second;
  logic [GCM_LINES-1:0] right_drive_first, right_drive_second;

  // spines
  logic [GCM_BOTTOM_LINES-1:0] bottom_spine, top_spine;
  logic [GCM_LINES-1:0] center_spine;

  // quadrant line registers
  logic [GCM_QUADS-1:0][GCM_LINES-1:0] quad_clock_reg, quad_clock_next;

  // top and bottom matrices: slot 0 of a pair takes the odd line pin, slot 1 the even
  genvar gp, gs;
  generate
    for (gp = 0; gp < GCM_PAIRS; gp++) begin : g_global_pair
      for (gs = 0; gs < GCM_SLOTS; gs++) begin : g_slot
        localparam int PIN = 2 * gp + 1 - gs;
        always_comb begin
          global_slot[2 * gp + gs] = slot_pick(
            global_slot_src[2 * gp + gs],
            global_clock_pin[PIN],
            global_clock_pin[alt_global_pin(PIN)],
            global_manager_clock[2 * gp + gs],
            global_fabric_clock[gp],
            1'b1,
            1'b1);
        end
      end
    end
  endgenerate

  // side matrices: one dedicated pin per slot, manager only where present
  generate
    for (gp = 0; gp < GCM_PAIRS; gp++) begin : g_side_pair
      for (gs = 0; gs < GCM_SLOTS; gs++) begin : g_slot
        localparam int LPIN = 2 * gp + 1 - gs;
        localparam int RPIN = (LPIN + GCM_RIGHT_PIN_ROTATE) % GCM_HALF_PINS;
        always_comb begin
          left_slot[2 * gp + gs] = slot_pick(
            left_slot_src[2 * gp + gs],
            left_half_clock_pin[LPIN],
            1'b0,
            left_manager_clock[2 * gp + gs],
            left_fabric_clock[gp],
            1'b0,
            HAS_SIDE_MANAGER);
          right_slot[2 * gp + gs] = slot_pick(
            right_slot_src[2 * gp + gs],
            right_half_clock_pin[RPIN],
            1'b0,
            right_manager_clock[2 * gp + gs],
            right_fabric_clock[gp],
            1'b0,
            HAS_SIDE_MANAGER);
        end
      end
    end
  endgenerate

  // pair sharing: odd line takes slot 0 first, even line takes slot 1 first
  genvar gl;
  generate
    for (gl = 0; gl < GCM_LINES; gl++) begin : g_line_inputs
      localparam int PAIR = gl / 2;
      localparam int PRIMARY = 2 * PAIR + ((gl % 2 == 1) ? 0 : 1);
      localparam int PARTNER = 2 * PAIR + ((gl % 2 == 1) ? 1 : 0);
      assign global_first[gl] = global_slot[PRIMARY];
      assign global_second[gl] = global_slot[PARTNER];
      assign left_first[gl] = left_slot[PRIMARY];
      assign left_second[gl] = left_slot[PARTNER];
      assign right_first[gl] = right_slot[PRIMARY];
      assign right_second[gl] = right_slot[PARTNER];
    end
  endgenerate

  // eight global (four bottom, four top), eight left, eight right elements
  generate
    for (gl = 0; gl < GCM_LINES; gl++) begin : g_mux
      gcm_glitchless_clock_mux u_global (
        .clock(clock),
        .rst_n(rst_n),
        .clock_in_first(global_first[gl]),
        .clock_in_second(global_second[gl]),
        .select(global_select[gl]),
        .clock_out(global_out[gl]),
        .drive_first(global_drive_first[gl]),
        .drive_second(global_drive_second[gl])
      );
      gcm_glitchless_clock_mux u_left (
        .clock(clock),
        .rst_n(rst_n),
        .clock_in_first(left_first[gl]),
        .clock_in_second(left_second[gl]),
        .select(left_select[gl]),
        .clock_out(left_out[gl]),
        .drive_first(left_drive_first[gl]),
        .drive_second(left_drive_second[gl])
      );
      gcm_glitchless_clock_mux u_right (
        .clock(clock),
        .rst_n(rst_n),
        .clock_in_first(right_first[gl]),
        .clock_in_second(right_second[gl]),
        .select(right_select[gl]),
        .clock_out(right_out[gl]),
        .drive_first(right_drive_first[gl]),
        .drive_second(right_drive_second[gl])
      );
    end
  endgenerate

  // bottom elements drive lines A-D, top elements E-H
  assign bottom_spine = global_out[GCM_BOTTOM_LINES-1:0];
  assign top_spine = global_out[GCM_LINES-1:GCM_BOTTOM_LINES];
  assign center_spine = {top_spine, bottom_spine};

  // quadrant line selection
  always_comb begin
    quad_clock_next = quad_clock_reg;
    for (int q = 0; q < GCM_QUADS; q++) begin
      for (int l = 0; l < GCM_LINES; l++) begin
        if (quad_line_src[q][l] == GCM_LINE_GLOBAL) begin
          quad_clock_next[q][l] = center_spine[l];
        end else if (q == GCM_QUAD_BL || q == GCM_QUAD_TL) begin
          quad_clock_next[q][l] = left_out[l];
        end else begin
          quad_clock_next[q][l] = right_out[l];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      quad_clock_reg <= '0;
    end else begin
      quad_clock_reg <= quad_clock_next;
    end
  end

  assign quad_clock = quad_clock_reg;

  // plain buffer: same element, select tied to the first input
  gcm_glitchless_clock_mux u_plain_buffer (
    .clock(clock),
    .rst_n(rst_n),
    .clock_in_first(plain_buffer_in),
    .clock_in_second(1'b0),
    .select(GCM_SEL_FIRST),
    .clock_out(plain_buffer_out),
    .drive_first(),
    .drive_second()
  );

  // gated buffer: disable selects a constant low input, so the output parks low
  // and re-enable waits for a falling edge of the clock
  logic gated_select;
  assign gated_select = gated_buffer_enable ? GCM_SEL_FIRST : GCM_SEL_SECOND;

  gcm_glitchless_clock_mux u_gated_buffer (
    .clock(clock),
    .rst_n(rst_n),
    .clock_in_first(gated_buffer_in),
    .clock_in_second(GCM_CLK_IDLE),
    .select(gated_select),
    .clock_out(gated_buffer_out),
    .drive_first(),
    .drive_second()
  );

  // status: global 0-7, left 8-15, right 16-23
  assign mux_running = {right_drive_first | right_drive_second,
                        left_drive_first | left_drive_second,
                        global_drive_first | global_drive_second};
  assign mux_on_second = {right_drive_second, left_drive_second, global_drive_second};
endmodule

//--- common/gcm_pkg.sv
// constants and types shared by the clock multiplexer network
// assumes every clock input is a level sampled on the 200 MHz system clock
package gcm_pkg;
  // system clock
  localparam int GCM_CLK_PERIOD_NS = 5;
  // network geometry
  localparam int GCM_LINES = 8;
  localparam int GCM_QUADS = 4;
  localparam int GCM_PAIRS = 4;
  localparam int GCM_SLOTS = 2;
  localparam int GCM_EDGE_SLOTS = 8;
  localparam int GCM_MUX_TOTAL = 24;
  localparam int GCM_GLOBAL_PINS = 16;
  localparam int GCM_HALF_PINS = 8;
  localparam int GCM_BOTTOM_LINES = 4;
  // global pin aliasing: bottom pairs reach pin+12, top pairs pin+4
  localparam int GCM_ALT_SHIFT_BOTTOM = 12;
  localparam int GCM_ALT_SHIFT_TOP = 4;
  // right edge pins are rotated by four against the lines
  localparam int GCM_RIGHT_PIN_ROTATE = 4;
  // quadrant numbering
  localparam int GCM_QUAD_TR = 0;
  localparam int GCM_QUAD_BR = 1;
  localparam int GCM_QUAD_BL = 2;
  localparam int GCM_QUAD_TL = 3;
  // select encoding
  localparam logic GCM_SEL_FIRST = 1'b0;
  localparam logic GCM_SEL_SECOND = 1'b1;
  // quadrant line source encoding
  localparam logic GCM_LINE_GLOBAL = 1'b0;
  localparam logic GCM_LINE_HALF = 1'b1;
  // reset value of every forwarded clock
  localparam logic GCM_CLK_IDLE = 1'b0;

  typedef enum logic [1:0] {
    GCM_SRC_PIN_A,
    GCM_SRC_PIN_B,
    GCM_SRC_MANAGER,
    GCM_SRC_FABRIC
  } gcm_src_e;

  typedef enum logic [1:0] {
    GCM_MUX_IDLE,
    GCM_MUX_FIRST,
    GCM_MUX_SECOND
  } gcm_mux_state_e;
endpackage

//--- hw/gcm_glitchless_clock_mux.sv
// one glitchless two-input clock multiplexer element
// assumes both clock inputs and select are sampled on the system clock
`timescale 1ns/100ps
module gcm_glitchless_clock_mux (
  // system
  input logic clock,
  input logic rst_n,
  // sampled clocks and select
  input logic clock_in_first,
  input logic clock_in_second,
  input logic select,
  // forwarded clock and status
  output logic clock_out,
  output logic drive_first,
  output logic drive_second
);
  import gcm_pkg::*;

  gcm_mux_state_e state_reg, state_next;
  logic first_prev_reg, first_prev_next;
  logic second_prev_reg, second_prev_next;
  logic out_reg, out_next;
  logic first_fall, second_fall;

  always_comb begin
    first_fall = first_prev_reg & ~clock_in_first;
    second_fall = second_prev_reg & ~clock_in_second;
    first_prev_next = clock_in_first;
    second_prev_next = clock_in_second;
    state_next = state_reg;
    unique case (state_reg)
      GCM_MUX_IDLE: begin
        // join only after a falling edge, so the first high phase is whole
        if (select == GCM_SEL_FIRST && first_fall) begin
          state_next = GCM_MUX_FIRST;
        end else if (select == GCM_SEL_SECOND && second_fall) begin
          state_next = GCM_MUX_SECOND;
        end
      end
      GCM_MUX_FIRST: begin
        // leave only while the old clock is low
        if (select == GCM_SEL_SECOND && !clock_in_first) begin
          state_next = GCM_MUX_IDLE;
        end
      end
      GCM_MUX_SECOND: begin
        if (select == GCM_SEL_FIRST && !clock_in_second) begin
          state_next = GCM_MUX_IDLE;
        end
      end
      default: begin
        state_next = GCM_MUX_IDLE;
      end
    endcase
    // select is sampled, so a late change costs a cycle, never a runt
    out_next = (state_reg == GCM_MUX_FIRST && clock_in_first) ||
               (state_reg == GCM_MUX_SECOND && clock_in_second);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= GCM_MUX_IDLE;
      first_prev_reg <= 1'b0;
      second_prev_reg <= 1'b0;
      out_reg <= GCM_CLK_IDLE;
    end else begin
      state_reg <= state_next;
      first_prev_reg <= first_prev_next;
      second_prev_reg <= second_prev_next;
      out_reg <= out_next;
    end
  end

  assign clock_out = out_reg;
  assign drive_first = (state_reg == GCM_MUX_FIRST);
  assign drive_second = (state_reg == GCM_MUX_SECOND);
endmodule

//--- dv/gcm_clock_source.sv
// behavioural clock source standing in for pins, managers and fabric lines
// assumes the bench clock samples the level; it changes just after rising edges
`timescale 1ns/100ps
module gcm_clock_source #(
  parameter int HIGH = 2,
  parameter int LOW = 2
) (
  // system
  input wire logic clock,
  // control and level
  input wire logic run,
  output logic level
);
  int count;
  initial begin
    level = 1'b0;
    count = 0;
  end
  // own period per instance, so sources are unrelated; stands low when stopped
  always @(posedge clock) begin
    if (!run) begin
      level <= 1'b0;
      count <= 0;
    end else if (count + 1 >= (level ? HIGH : LOW)) begin
      level <= !level;
      count <= 0;
    end else begin
      count <= count + 1;
    end
  end
endmodule

//--- dv/gcm_clock_network_asserts.sv
// concurrent checks on the clock network top ports
// assumes a bind into the network; one system clock domain
`timescale 1ns/100ps
module gcm_clock_network_asserts (
  // system
  input logic clock,
  input logic rst_n,
  // sources and configuration
  input logic [15:0] global_clock_pin,
  input logic [7:0] left_half_clock_pin,
  input logic [7:0] right_half_clock_pin,
  input gcm_pkg::gcm_src_e [7:0] global_slot_src,
  input gcm_pkg::gcm_src_e [7:0] left_slot_src,
  input gcm_pkg::gcm_src_e [7:0] right_slot_src,
  input logic [3:0][7:0] quad_line_src,
  input logic plain_buffer_in,
  input logic gated_buffer_in,
  input logic gated_buffer_enable,
  // forwarded clocks and status
  input logic plain_buffer_out,
  input logic gated_buffer_out,
  input logic [3:0][7:0] quad_clock,
  input logic [23:0] mux_running,
  input logic [23:0] mux_on_second
);
  import gcm_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_parked;
    !gated_buffer_enable && !gated_buffer_in;
  endsequence
  // line fed only by quiet pins must settle low within the pipeline
  property p_quiet(pins, srcs, sel, line);
    (pins == 2'h0 && srcs == 4'h0 && sel)[*4] |-> !line;
  endproperty
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> quad_clock == '0 && mux_running == '0
    && !plain_buffer_out && !gated_buffer_out) else $error("outputs not cleared by reset");
  a_plain_source: assert property (plain_buffer_out |-> $past(plain_buffer_in))
    else $error("plain output high without input");
  a_gated_source: assert property (gated_buffer_out |-> $past(gated_buffer_in))
    else $error("gated output high without input");
  a_gated_parks: assert property (s_parked ##1 (!gated_buffer_enable)[*2] |-> !gated_buffer_out)
    else $error("disabled gated output not static");
  a_second_subset: assert property ((mux_on_second & ~mux_running) == '0)
    else $error("second flagged on idle element");
  a_switch_idle: assert property ($rose(mux_on_second[8]) |-> !$past(mux_running[8]))
    else $error("switch skipped the idle gap");
  a_bl_quiet: assert property (p_quiet(left_half_clock_pin[1:0], left_slot_src[1:0], quad_line_src[2][0],
    quad_clock[2][0])) else $error("bl line a active while idle");
  a_tl_quiet: assert property (p_quiet(left_half_clock_pin[1:0], left_slot_src[1:0], quad_line_src[3][0],
    quad_clock[3][0])) else $error("tl line a active while idle");
  a_br_quiet: assert property (p_quiet(right_half_clock_pin[5:4], right_slot_src[1:0], quad_line_src[1][0],
    quad_clock[1][0])) else $error("br line a active while idle");
  a_tr_quiet: assert property (p_quiet(global_clock_pin[5:4], global_slot_src[5:4], !quad_line_src[0][4],
    quad_clock[0][4])) else $error("tr line e active while idle");
endmodule

//--- dv/tb.sv
// self-checking bench for the quadrant clock network
// assumes the source model and the checker are compiled before it
`timescale 1ns/100ps
module tb;
  import gcm_pkg::*;
  logic clock, rst_n, on, ca, cb, cc, cd;
  logic [15:0] global_clock_pin;
  logic [7:0] left_half_clock_pin, right_half_clock_pin, global_manager_clock, global_fabric_clock;
  logic [7:0] global_select, left_select, right_select;
  logic [7:0] left_manager_clock, right_manager_clock;
  logic [3:0] left_fabric_clock, right_fabric_clock;
  gcm_src_e [7:0] global_slot_src, left_slot_src, right_slot_src;
  logic [3:0][7:0] quad_line_src, quad_clock;
  logic plain_buffer_in, plain_buffer_out, gated_buffer_in, gated_buffer_enable, gated_buffer_out;
  logic [23:0] mux_running, mux_on_second;
  int mismatches, num_checks;
  // periods 4, 8, 10, 16: rises in 80 cycles are 20, 10, 8, 5
  gcm_clock_source #(.HIGH(2), .LOW(2)) src_a (.clock, .run(on), .level(ca));
  gcm_clock_source #(.HIGH(3), .LOW(5)) src_b (.clock, .run(on), .level(cb));
  gcm_clock_source #(.HIGH(5), .LOW(5)) src_c (.clock, .run(on), .level(cc));
  gcm_clock_source #(.HIGH(8), .LOW(8)) src_d (.clock, .run(on), .level(cd));
  assign global_clock_pin = {7'h0, cb, 2'h0, cd, ca, 4'h0};
  assign left_half_clock_pin = {6'h0, cb, ca};
  assign right_half_clock_pin = {3'h0, cc, 4'h0};
  assign global_manager_clock = {2'h0, cc, 5'h0};
  assign global_fabric_clock = {5'h0, cd, 2'h0};
  // side manager and fabric sources feed slot 1 and pair 0 of each side matrix
  assign left_manager_clock = {6'h0, cc, 1'b0};
  assign right_manager_clock = {6'h0, cd, 1'b0};
  assign left_fabric_clock = {3'h0, cd};
  assign right_fabric_clock = {3'h0, cb};
  assign plain_buffer_in = ca;
  assign gated_buffer_in = ca;
  always #2.5 clock = ~clock;
  gcm_clock_network gcm_clock_network_i (
    .clock, .rst_n, .global_clock_pin, .left_half_clock_pin, .right_half_clock_pin, .global_manager_clock,
    .left_manager_clock, .right_manager_clock, .global_fabric_clock, .left_fabric_clock,
    .right_fabric_clock, .global_slot_src, .left_slot_src, .right_slot_src, .global_select, .left_select,
    .right_select, .quad_line_src, .plain_buffer_in, .plain_buffer_out, .gated_buffer_in,
    .gated_buffer_enable, .gated_buffer_out, .quad_clock, .mux_running, .mux_on_second
  );
  task automatic check(input string what, input logic [31:0] want, input logic [31:0] got);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", what, want, got);
    end
  endtask
  function automatic logic probe(input int s);
    if (s == 32) return plain_buffer_out;
    if (s == 33) return gated_buffer_out;
    return quad_clock[s / 8][s % 8];
  endfunction
  // counts rises and shortest full phase; tgl 1 or 2 flips a select every 7 cycles
  task automatic measure(input int s, input int tgl, output int rises, output int minph);
    logic prev, cur;
    int run;
    bit seen;
    rises = 0;
    minph = 1000;
    run = 0;
    seen = 0;
    @(posedge clock);
    #1 prev = probe(s);
    for (int i = 0; i < 80; i++) begin
      @(posedge clock);
      if (tgl == 1 && i % 7 == 6) left_select[0] <= !left_select[0];
      if (tgl == 2 && i % 7 == 6) gated_buffer_enable <= !gated_buffer_enable;
      #1 cur = probe(s);
      run++;
      if (cur !== prev) begin
        if (seen && run < minph) minph = run;
        seen = 1;
        run = 0;
        if (cur === 1'b1) rises++;
      end
      prev = cur;
    end
  endtask
  task automatic rate(input int s, input int want);
    int r, m;
    repeat (24) @(posedge clock);
    measure(s, 0, r, m);
    check($sformatf("rises on probe %0d", s), want, r);
    @(posedge clock);
  endtask
  task automatic t_left;
    rate(16, 20);
    rate(24, 20);
    rate(8, 8);
    rate(0, 8);
    rate(17, 10);
    #1 check("line a status", 2'h2, {mux_running[8], mux_on_second[8]});
    @(posedge clock);
    left_select[0] <= 1'b1;
    rate(16, 10);
    #1 check("line a status", 2'h3, {mux_running[8], mux_on_second[8]});
    @(posedge clock);
    left_select[0] <= 1'b0;
    left_slot_src[1] <= GCM_SRC_PIN_B;
    rate(16, 0);
    left_slot_src[1] <= GCM_SRC_MANAGER;
    rate(16, 8);
    left_slot_src[1] <= GCM_SRC_FABRIC;
    rate(16, 5);
    right_slot_src[1] <= GCM_SRC_MANAGER;
    rate(0, 5);
    right_slot_src[1] <= GCM_SRC_PIN_A;
    right_select[0] <= 1'b1;
    rate(0, 0);
    right_select[0] <= 1'b0;
    left_slot_src[1] <= GCM_SRC_PIN_A;
    $display("t_left done");
  endtask
  task automatic t_global;
    int want[4] = '{20, 10, 8, 5};
    for (int c = 0; c < 4; c++) begin
      global_slot_src[5] <= gcm_src_e'(c);
      for (int q = 0; q < 4; q++) begin
        rate(q * 8 + 4, want[c]);
      end
    end
    global_slot_src[5] <= GCM_SRC_PIN_A;
    global_select[4] <= 1'b1;
    rate(12, 5);
    global_select[4] <= 1'b0;
    quad_line_src[0][4] <= 1'b1;
    rate(4, 0);
    rate(12, 20);
    $display("t_global done");
  endtask
  task automatic t_switch;
    int r, m;
    measure(16, 1, r, m);
    check("switch min phase", 1'b1, m >= 2);
    check("switch toggles", 1'b1, r > 0);
    @(posedge clock);
    left_select[0] <= 1'b0;
    rate(32, 20);
    $display("t_switch done");
  endtask
  task automatic t_gated;
    int r, m;
    gated_buffer_enable <= 1'b1;
    rate(33, 20);
    gated_buffer_enable <= 1'b0;
    rate(33, 0);
    #1 check("gated idle level", GCM_CLK_IDLE, gated_buffer_out);
    measure(33, 2, r, m);
    check("gated min phase", 1'b1, m >= 2);
    @(posedge clock);
    gated_buffer_enable <= 1'b1;
    rate(33, 20);
    $display("t_gated done");
  endtask
  task automatic t_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check("reset outputs", 1'b1, {quad_clock, mux_running, mux_on_second, plain_buffer_out,
      gated_buffer_out} === '0);
    @(posedge clock);
    rst_n <= 1'b1;
    rate(16, 20);
    $display("t_reset done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    on = 1'b0;
    global_select = 8'h0;
    left_select = 8'h0;
    right_select = 8'h0;
    quad_line_src = {4{8'h03}};
    gated_buffer_enable = 1'b0;
    mismatches = 0;
    num_checks = 0;
    foreach (global_slot_src[i]) begin
      global_slot_src[i] = GCM_SRC_PIN_A;
      left_slot_src[i] = GCM_SRC_PIN_A;
      right_slot_src[i] = GCM_SRC_PIN_A;
    end
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    on <= 1'b1;
    t_left();
    t_global();
    t_switch();
    t_gated();
    t_reset();
    conclude();
  end
endmodule
bind gcm_clock_network gcm_clock_network_asserts gcm_clock_network_asserts_i (
  .clock, .rst_n, .global_clock_pin, .left_half_clock_pin, .right_half_clock_pin, .global_slot_src,
  .left_slot_src, .right_slot_src, .quad_line_src, .plain_buffer_in, .gated_buffer_in, .gated_buffer_enable,
  .plain_buffer_out, .gated_buffer_out, .quad_clock, .mux_running, .mux_on_second
);
